// [common/esirq_regs.vh]
// register map, field positions and timing constants of the event block
// =====================================================================
// Contract
// - status reads valid only with processor power
// - masked status change sets pending bit fifteen
// - interrupt pin low when pending and enabled
// - status read clears bits one to fifteen
// - ready flag cleared only by programming write
// - reserved status bits fourteen, two, one read zero
// - tone and squelch flags zero in transmit
// - squelch turn-off tone reported as squelch event
// - maintenance tone change reported as sub-audio event
// - receive address match sets bit twelve
// - transmit fourth tone end sets bit twelve
// - bits nine, eight hold threshold crossing history
// - sample register holds latest conversion result
// - sample readable only with processor power
// - bits four, three hold detected data rate
// - bit six flags modem data transfer needed
// - ready flag returns when programming completes
// - bit five updated by block check result
`ifndef ESIRQ_REGS_VH
`define ESIRQ_REGS_VH

// =====================================================================
// register addresses on the serial control bus
`define ESIRQ_ADDR_ADC     8'hb4
`define ESIRQ_ADDR_STATUS  8'hc6
`define ESIRQ_ADDR_PROG    8'hc8
`define ESIRQ_ADDR_MASK    8'hce

// =====================================================================
// status and mask bit positions
`define ESIRQ_B_IRQ     15
`define ESIRQ_B_INBAND  13
`define ESIRQ_B_ADDRSET 12
`define ESIRQ_B_SUBAUD  11
`define ESIRQ_B_DCS     10
`define ESIRQ_B_ADC_HI  9
`define ESIRQ_B_ADC_LO  8
`define ESIRQ_B_DEND    7
`define ESIRQ_B_DXFER   6
`define ESIRQ_B_CRC     5
`define ESIRQ_B_R2400   4
`define ESIRQ_B_R1200   3
`define ESIRQ_B_PROG    0

// =====================================================================
// field groups and reset values
`define ESIRQ_MASK_EN     16'h3fd9
`define ESIRQ_MASK_KEEP   16'hbfd9
`define ESIRQ_RATE_RSVD   2'h3
`define ESIRQ_TX_ZERO     16'h2c00
`define ESIRQ_RD_CLEAR    16'hfffe
`define ESIRQ_RESERVED    16'h4006
`define ESIRQ_STATUS_RST  16'h0001
`define ESIRQ_MASK_RST    16'h0000
`define ESIRQ_ADC_RST     8'h00

// =====================================================================
// serial frame bit counts
`define ESIRQ_CNT_ADDR  5'd8
`define ESIRQ_CNT_BYTE  5'd16
`define ESIRQ_CNT_WORD  5'd24

// =====================================================================
// timing
`define ESIRQ_CLK_NS        4
`define ESIRQ_PROG_TIME_NS  250000

`endif

// [src/esirq_sync.v]
// two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/10ps
module esirq_sync #(
  parameter W = 3
) (
  input  wire         clk,
  input  wire         rst_b,
  input  wire [W-1:0] pin_in,
  output reg  [W-1:0] pin_sync
);

  reg [W-1:0] meta;

  // =====================================================================
  // first stage feeds only the second stage
  always @(posedge clk) begin
    if (!rst_b) begin
      meta     <= {W{1'b0}};
      pin_sync <= {W{1'b0}};
    end else begin
      meta     <= pin_in;
      pin_sync <= meta;
    end
  end

endmodule // esirq_sync

// [src/esirq_top.v]
// event status word, interrupt mask and sample register with serial slave
`timescale 1ns/10ps
`include "esirq_regs.vh"
module esirq_top #(
  parameter PROG_CYCLES = `ESIRQ_PROG_TIME_NS / `ESIRQ_CLK_NS,
  parameter TW          = 17
) (
  input  wire        clk,
  input  wire        rst_b,
  input  wire        cmd_clk,
  input  wire        cmd_sel_n,
  input  wire        cmd_in,
  output reg         reply_out,
  output reg         reply_oe,
  output reg         interrupt_out_n,
  output reg         prog_write,
  output reg  [15:0] prog_data,
  input  wire        proc_power,
  input  wire        tx_mode,
  input  wire        inband_change,
  input  wire        subaudio_change,
  input  wire        maint_tone_change,
  input  wire        dcs_change,
  input  wire        dcs_turnoff_change,
  input  wire        addr_set_match,
  input  wire        addr_tone4_done,
  input  wire        adc_above_high,
  input  wire        adc_below_low,
  input  wire        adc_conv_done,
  input  wire [7:0]  adc_result,
  input  wire        data_end,
  input  wire        data_xfer,
  input  wire        crc_update,
  input  wire        crc_error,
  input  wire        rate_valid,
  input  wire [1:0]  rate_code,
  input  wire        prog_done
);

  // =====================================================================
  // helpers
  // number of clock edges after which a read of this address is complete
  function [4:0] reply_end;
    input [7:0] a;
    begin
      if (a == `ESIRQ_ADDR_ADC)
        reply_end = `ESIRQ_CNT_BYTE;
      else if (a == `ESIRQ_ADDR_STATUS)
        reply_end = `ESIRQ_CNT_WORD;
      else
        reply_end = 5'd0;
    end
  endfunction

  function is_write_addr;
    input [7:0] a;
    begin
      is_write_addr = (a == `ESIRQ_ADDR_MASK) || (a == `ESIRQ_ADDR_PROG);
    end
  endfunction

  // word loaded into the reply shifter, msb first; unpowered reads give zero
  function [15:0] reply_word;
    input [7:0]  a;
    input [15:0] stat;
    input [7:0]  smp;
    input        pwr;
    begin
      if (!pwr)
        reply_word = 16'h0000;
      else if (a == `ESIRQ_ADDR_STATUS)
        reply_word = stat;
      else
        reply_word = {smp, 8'h00};
    end
  endfunction

  // =====================================================================
  // pin synchronisation and link clock edges
  wire [2:0] pins_sync;
  reg        sclk_prev;
  wire       s_clk;
  wire       s_sel_n;
  wire       s_din;
  wire       sclk_rise;
  wire       sclk_fall;

  // select enters inverted so that the reset value reads as deselected
  esirq_sync #(
    .W (3)
  ) u_sync (
    .clk      (clk),
    .rst_b    (rst_b),
    .pin_in   ({cmd_clk, ~cmd_sel_n, cmd_in}),
    .pin_sync (pins_sync)
  );

  assign s_clk     = pins_sync[2];
  assign s_sel_n   = ~pins_sync[1];
  assign s_din     = pins_sync[0];
  assign sclk_rise = s_clk & ~sclk_prev & ~s_sel_n;
  assign sclk_fall = ~s_clk & sclk_prev & ~s_sel_n;

  always @(posedge clk) begin
    if (!rst_b)
      sclk_prev <= 1'b0;
    else
      sclk_prev <= s_clk;
  end

  // =====================================================================
  // serial frame: 8 address bits then 16 data bits in, or 8/16 out
  reg  [4:0]  bit_cnt;
  reg  [7:0]  addr_sr;
  reg  [15:0] data_sr;
  reg  [15:0] reply_sr;
  reg  [15:0] status;
  reg  [15:0] irq_mask;
  reg  [7:0]  adc_data;
  reg  [15:0] snap;
  wire [4:0]  rd_end;
  wire [15:0] wr_word;
  wire        wr_commit;
  wire        stat_clr;
  wire        last_rise;
  wire        mask_wr_now;
  wire        prog_wr_now;
  wire [15:0] load_word;

  assign rd_end      = reply_end(addr_sr);
  assign wr_word     = {data_sr[14:0], s_din};
  // last rising link edge of a full frame
  assign last_rise   = sclk_rise && (bit_cnt == `ESIRQ_CNT_WORD - 5'd1);
  assign wr_commit   = last_rise && is_write_addr(addr_sr);
  assign mask_wr_now = wr_commit && (addr_sr == `ESIRQ_ADDR_MASK);
  assign prog_wr_now = wr_commit && (addr_sr == `ESIRQ_ADDR_PROG);
  assign load_word   = reply_word(addr_sr, status, adc_data, proc_power);
  // clear fires as the host takes the last status bit
  assign stat_clr    = last_rise && (addr_sr == `ESIRQ_ADDR_STATUS);

  always @(posedge clk) begin
    if (!rst_b) begin
      bit_cnt <= 5'd0;
      addr_sr <= 8'h00;
      data_sr <= 16'h0000;
    end else if (s_sel_n) begin
      bit_cnt <= 5'd0;
    end else if (sclk_rise) begin
      if (bit_cnt < `ESIRQ_CNT_ADDR)
        addr_sr <= {addr_sr[6:0], s_din};
      else
        data_sr <= wr_word;
      if (bit_cnt != `ESIRQ_CNT_WORD)
        bit_cnt <= bit_cnt + 5'd1;
    end
  end

  // =====================================================================
  // reply shifter; data changes on falling link edge, host samples rising
  always @(posedge clk) begin
    if (!rst_b) begin
      reply_sr  <= 16'h0000;
      reply_out <= 1'b0;
      reply_oe  <= 1'b0;
      snap      <= 16'h0000;
    end else if (s_sel_n) begin
      reply_oe  <= 1'b0;
      reply_out <= 1'b0;
    end else if (sclk_fall) begin
      if (bit_cnt == `ESIRQ_CNT_ADDR && rd_end != 5'd0) begin
        reply_oe  <= 1'b1;
        // the clear uses the real word even when the reply is blanked
        snap      <= status;
        reply_sr  <= load_word;
        reply_out <= load_word[15];
      end else if (reply_oe && bit_cnt < rd_end) begin
        reply_sr  <= {reply_sr[14:0], 1'b0};
        // power may drop mid-frame; the pin then reads zero
        reply_out <= proc_power & reply_sr[14];
      end
    end
  end

  // =====================================================================
  // mask register and programming write strobe
  always @(posedge clk) begin
    if (!rst_b) begin
      irq_mask   <= `ESIRQ_MASK_RST;
      prog_write <= 1'b0;
      prog_data  <= 16'h0000;
    end else begin
      prog_write <= 1'b0;
      // reserved mask positions are stored as zero
      if (mask_wr_now)
        irq_mask <= wr_word & `ESIRQ_MASK_KEEP;
      if (prog_wr_now) begin
        prog_write <= 1'b1;
        prog_data  <= wr_word;
      end
    end
  end

  // =====================================================================
  // sample register
  always @(posedge clk) begin
    if (!rst_b)
      adc_data <= `ESIRQ_ADC_RST;
    else if (adc_conv_done)
      adc_data <= adc_result;
  end

  // =====================================================================
  // programming completion timer, a fallback if no done strobe arrives
  reg  [TW-1:0] prog_timer;
  wire          prog_ready;

  // a second write while busy restarts the wait
  assign prog_ready  = prog_done || (prog_timer == {{(TW-1){1'b0}}, 1'b1});

  always @(posedge clk) begin
    if (!rst_b)
      prog_timer <= {TW{1'b0}};
    else if (prog_wr_now)
      prog_timer <= PROG_CYCLES[TW-1:0];
    else if (prog_done)
      prog_timer <= {TW{1'b0}};
    else if (prog_timer != {TW{1'b0}})
      prog_timer <= prog_timer - {{(TW-1){1'b0}}, 1'b1};
  end

  // =====================================================================
  // event vector
  reg [15:0] ev;
  wire       rate_ok;

  // the reserved rate code is never reported
  assign rate_ok = rate_valid & (rate_code != `ESIRQ_RATE_RSVD);

  always @* begin
    ev = 16'h0000;
    ev[`ESIRQ_B_INBAND]  = inband_change;
    ev[`ESIRQ_B_ADDRSET] = tx_mode ? addr_tone4_done
                                   : addr_set_match;
    ev[`ESIRQ_B_SUBAUD]  = subaudio_change | maint_tone_change;
    ev[`ESIRQ_B_DCS]     = dcs_change | dcs_turnoff_change;
    ev[`ESIRQ_B_ADC_HI]  = adc_above_high;
    ev[`ESIRQ_B_ADC_LO]  = adc_below_low;
    ev[`ESIRQ_B_DEND]    = data_end;
    ev[`ESIRQ_B_DXFER]   = data_xfer;
    ev[`ESIRQ_B_R2400]   = rate_ok & rate_code[1];
    ev[`ESIRQ_B_R1200]   = rate_ok & rate_code[0];
    if (tx_mode)
      ev = ev & ~`ESIRQ_TX_ZERO;
  end

  // =====================================================================
  // status word next value
  reg  [15:0] clr_bits;
  reg  [15:0] next_status;
  reg  [15:0] rise;
  reg         pend_left;
  reg         pend_set;
  reg         pend_hold;
  reg         pend_relatch;

  always @* begin
    clr_bits = stat_clr ? (snap & `ESIRQ_RD_CLEAR) : 16'h0000;
    // only the reported bits clear; events after the snapshot survive
    next_status = (status & ~clr_bits) | ev;
    if (crc_update)
      next_status[`ESIRQ_B_CRC] = crc_error;
    if (prog_wr_now)
      next_status[`ESIRQ_B_PROG] = 1'b0;
    if (prog_ready)
      next_status[`ESIRQ_B_PROG] = 1'b1;
    if (tx_mode)
      next_status = next_status & ~`ESIRQ_TX_ZERO;
    next_status = next_status & ~`ESIRQ_RESERVED;
    rise = next_status & ~status & `ESIRQ_MASK_EN & irq_mask;
    pend_left = |(next_status & ~snap & `ESIRQ_MASK_EN & irq_mask);
    // pending holds unless read out, and relatches for later events
    pend_set     = |rise;
    pend_hold    = status[`ESIRQ_B_IRQ] & ~clr_bits[`ESIRQ_B_IRQ];
    pend_relatch = clr_bits[`ESIRQ_B_IRQ] & pend_left;
    next_status[`ESIRQ_B_IRQ] = pend_set | pend_hold | pend_relatch;
  end

  always @(posedge clk) begin
    if (!rst_b)
      status <= `ESIRQ_STATUS_RST;
    else
      status <= next_status;
  end

  // =====================================================================
  // interrupt pin, registered so it never glitches
  always @(posedge clk) begin
    if (!rst_b)
      interrupt_out_n <= 1'b1;
    else
      interrupt_out_n <= ~(status[`ESIRQ_B_IRQ] &
                           irq_mask[`ESIRQ_B_IRQ]);
  end

endmodule // esirq_top

// [dv/esirq_props.sv]
// checker for the event block ports
`timescale 1ns/10ps
module esirq_props (
  input wire        clk,
  input wire        rst_b,
  input wire        cmd_clk,
  input wire        cmd_sel_n,
  input wire        reply_out,
  input wire        reply_oe,
  input wire        interrupt_out_n,
  input wire        prog_write,
  input wire [15:0] prog_data,
  input wire        proc_power
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // =====================================================================
  // properties
  property p_hold;
    (cmd_sel_n [*6] ##0 !interrupt_out_n) |=> !interrupt_out_n;
  endproperty
  a_hold: assert property (p_hold) else $error("irq dropped w/o read");
  property p_prog_pulse;
    prog_write |=> !prog_write;
  endproperty
  a_prog_pulse: assert property (p_prog_pulse) else $error("prog pulse long");
  property p_prog_data;
    !prog_write |-> $stable(prog_data);
  endproperty
  a_prog_data: assert property (p_prog_data) else $error("prog data moved");
  property p_oe_stand;
    reply_oe && !cmd_sel_n |=> reply_oe;
  endproperty
  a_oe_stand: assert property (p_oe_stand) else $error("reply oe dropped");
  property p_oe_idle;
    cmd_sel_n [*8] |-> !reply_oe;
  endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("reply while idle");
  // reply bits move only 2..5 cycles after a bus clock fall
  property p_reply_edge;
    reply_oe && $past(reply_oe) && $changed(reply_out)
      |-> !$past(cmd_clk, 2) && $past(cmd_clk, 5);
  endproperty
  a_reply_edge: assert property (p_reply_edge) else $error("reply bit timing");
  property p_unpow;
    (!proc_power [*8] ##0 reply_oe) |-> !reply_out;
  endproperty
  a_unpow: assert property (p_unpow) else $error("unpowered read nonzero");
  property p_rel;
    $rose(rst_b) |-> interrupt_out_n && !reply_oe && !prog_write;
  endproperty
  a_rel: assert property (p_rel) else $error("outputs not idle at reset");
endmodule // esirq_props

bind esirq_top esirq_props u_props (.clk(clk), .rst_b(rst_b),
  .cmd_clk(cmd_clk), .cmd_sel_n(cmd_sel_n), .reply_out(reply_out),
  .reply_oe(reply_oe), .interrupt_out_n(interrupt_out_n),
  .prog_write(prog_write), .prog_data(prog_data), .proc_power(proc_power));

// [dv/esirq_host.sv]
// host model issuing serial control frames
`timescale 1ns/10ps
module esirq_host (
  output reg  cmd_clk,
  output reg  cmd_sel_n,
  output reg  cmd_in,
  input  wire reply_out,
  input  wire reply_oe
);
  reg  last;
  // undriven reply pin shows the inverse of the last bit seen
  wire line = reply_oe ? reply_out : ~last;
  initial begin
    cmd_clk = 1'b0;
    cmd_sel_n = 1'b1;
    cmd_in = 1'b0;
    last = 1'b0;
  end
  // =====================================================================
  // frame of nb rises, msb first; bus clock rests low between frames
  task xfer(input [7:0] a, input [15:0] d, input integer nb,
            output [15:0] q, output seen);
    reg [23:0] sh;
    integer    k;
    begin
      sh = {a, d};
      q = 16'h0000;
      seen = 1'b0;
      #1.3 cmd_sel_n = 1'b0;
      for (k = 0; k < nb; k = k + 1) begin
        #24 cmd_clk = 1'b0;
        cmd_in = sh[23];
        sh = sh << 1;
        #24 cmd_clk = 1'b1;
        if (k >= 8) begin
          q = {q[14:0], line};
          last = line;
          seen = seen | reply_oe;
        end
      end
      #24 cmd_clk = 1'b0;
      cmd_in = ~cmd_in;
      #24 cmd_sel_n = 1'b1;
      #40;
    end
  endtask
endmodule // esirq_host

// [dv/tb_top.sv]
// testbench for the event status and interrupt block
`timescale 1ns/10ps
`include "esirq_regs.vh"
module tb_top;
  reg         clk, rst_b, proc_power, tx_mode, crc_error, seen;
  reg  [15:0] ev, rd, e, prog_pulses;
  reg  [7:0]  adc_result;
  reg  [1:0]  rate_code;
  reg  [31:0] seed;
  wire        cmd_clk, cmd_sel_n, cmd_in, reply_out, reply_oe;
  wire        interrupt_out_n, prog_write;
  wire [15:0] prog_data;
  integer     fail_count, check_count, i;
  esirq_top #(.PROG_CYCLES(2000)) u_dut (.clk(clk), .rst_b(rst_b),
    .cmd_clk(cmd_clk), .cmd_sel_n(cmd_sel_n), .cmd_in(cmd_in),
    .reply_out(reply_out), .reply_oe(reply_oe),
    .interrupt_out_n(interrupt_out_n), .prog_write(prog_write),
    .prog_data(prog_data), .proc_power(proc_power), .tx_mode(tx_mode),
    .inband_change(ev[0]), .subaudio_change(ev[1]),
    .maint_tone_change(ev[2]), .dcs_change(ev[3]),
    .dcs_turnoff_change(ev[4]), .addr_set_match(ev[5]),
    .adc_above_high(ev[6]), .adc_below_low(ev[7]), .data_end(ev[8]),
    .data_xfer(ev[9]), .rate_valid(ev[10] | ev[11]),
    .rate_code(rate_code), .crc_update(ev[12]), .crc_error(crc_error),
    .addr_tone4_done(ev[13]), .adc_conv_done(ev[14]),
    .adc_result(adc_result), .prog_done(ev[15]));
  esirq_host u_host (.cmd_clk(cmd_clk), .cmd_sel_n(cmd_sel_n),
    .cmd_in(cmd_in), .reply_out(reply_out), .reply_oe(reply_oe));
  // =====================================================================
  // expectations
  function [31:0] xs(input [31:0] s);
    reg [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  // status after one event from source k, full mask enabled
  function [15:0] exp_ev(input integer k, input t);
    reg [15:0] b;
    begin
      b = 16'h0000;
      if (k < 13 && k != 5 || k == 5 && !t || k == 13 && t)
        b = 16'h0001 << ((k == 13) ? 12 : (k == 5) ? 12 : (k > 5) ?
            ((k > 9) ? k - 7 : 15 - k) : (k == 0) ? 13 : (k < 3) ? 11 : 10);
      if (t)
        b = b & 16'hd3ff;
      // the block check flag has no enable, so it never raises pending
      exp_ev = b | ((b & 16'hffdf) != 16'h0000 ? 16'h8001 : 16'h0001);
    end
  endfunction
  // =====================================================================
  // shared tasks
  task check16(input [15:0] got, input [15:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task check1(input got, input exp);
    begin
      check16({15'h0000, got}, {15'h0000, exp});
    end
  endtask
  task pulse(input integer k);
    begin
      @(negedge clk);
      rate_code = (k == 11) ? 2'h2 : 2'h1;
      ev[k] = 1'b1;
      @(negedge clk);
      ev[k] = 1'b0;
      repeat (3) @(negedge clk);
    end
  endtask
  task end_of_test;
    begin
      $display("checks %0d errors %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk)
    if (prog_write)
      prog_pulses <= prog_pulses + 16'h0001;
  initial begin
    repeat (90000) @(posedge clk);
    fail_count = fail_count + 1;
    end_of_test;
  end
  // =====================================================================
  // main sequence
  initial begin
    {rst_b, proc_power, tx_mode, crc_error, ev} = 20'h4_0000;
    {adc_result, rate_code, seed} = {10'h000, 32'hd2f4d244};
    fail_count = 0;
    prog_pulses = 16'h0000;
    check_count = 0;
    repeat (8) @(negedge clk);
    rst_b = 1'b1;
    crc_error = 1'b1;
    repeat (4) @(negedge clk);
    u_host.xfer(`ESIRQ_ADDR_STATUS, 16'h0000, 24, rd, seen);
    check16(rd, 16'h0001);
    u_host.xfer(`ESIRQ_ADDR_MASK, 16'hffff, 24, rd, seen);
    for (i = 0; i < 28; i = i + 1) begin
      @(negedge clk);
      tx_mode = i > 13;
      e = exp_ev(i % 14, tx_mode);
      pulse(i % 14);
      check1(interrupt_out_n, ~e[15]);
      u_host.xfer(`ESIRQ_ADDR_STATUS, 16'h0000, 24, rd, seen);
      check16(rd, e);
      check1(interrupt_out_n, 1'b1);
    end
    pulse(6);
    pulse(7);
    u_host.xfer(`ESIRQ_ADDR_STATUS, 16'h0000, 24, rd, seen);
    check16(rd, 16'h8301);
    pulse(12);
    @(negedge clk);
    crc_error = 1'b0;
    pulse(12);
    u_host.xfer(`ESIRQ_ADDR_STATUS, 16'h0000, 24, rd, seen);
    check16(rd, 16'h0001);
    for (i = 0; i < 4; i = i + 1) begin
      @(negedge clk);
      seed = xs(seed);
      proc_power = i < 3;
      adc_result = seed[7:0];
      pulse(14);
      u_host.xfer(`ESIRQ_ADDR_ADC, 16'h0000, 16, rd, seen);
      check16(rd, proc_power ? {8'h00, seed[7:0]} : 16'h0000);
    end
    u_host.xfer(`ESIRQ_ADDR_STATUS, 16'h0000, 24, rd, seen);
    check16(rd, 16'h0000);
    @(negedge clk);
    proc_power = 1'b1;
    u_host.xfer(`ESIRQ_ADDR_PROG, seed[31:16], 24, rd, seen);
    check16(prog_data, seed[31:16]);
    u_host.xfer(`ESIRQ_ADDR_STATUS, 16'h0000, 24, rd, seen);
    check16(rd, 16'h0000);
    repeat (2100) @(negedge clk);
    u_host.xfer(`ESIRQ_ADDR_STATUS, 16'h0000, 24, rd, seen);
    check16(rd, 16'h8001);
    u_host.xfer(`ESIRQ_ADDR_MASK, 16'h7fff, 24, rd, seen);
    pulse(8);
    check1(interrupt_out_n, 1'b1);
    u_host.xfer(`ESIRQ_ADDR_MASK, 16'h0000, 24, rd, seen);
    check1(seen, 1'b0);
    u_host.xfer(8'h00, 16'h0000, 24, rd, seen);
    check1(seen, 1'b0);
    u_host.xfer(`ESIRQ_ADDR_STATUS, 16'h0000, 24, rd, seen);
    check16(rd, 16'h8081);
    check16(prog_pulses, 16'h0001);
    end_of_test;
  end
endmodule // tb_top
